// >>> shared/pad_mux_pkg.sv
// Shared constants and carriers for the pad override and indicator mux.
// Assumes a single 100 MHz core clock and an APB master with 32-bit data.
package pad_mux_pkg;

    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_PAD_CFG = 12'h0461;
    localparam logic [11:0] IDX_IND_SEL = 12'h0462;
    localparam logic [11:0] IDX_IND_FUNC = 12'h0470;
    localparam logic [11:0] IDX_IND_STAT = 12'h0471;
    localparam int ADDR_W = 14;

    // Reset values
    localparam logic [15:0] RST_PAD_CFG = 16'h0005;
    localparam logic [15:0] RST_IND_SEL = 16'h0000;
    localparam logic [15:0] RST_IND_FUNC = 16'h0000;

    // Pad configuration fields
    localparam int POS_DIR_VAL = 15;
    localparam int POS_DIR_FORCE = 14;
    localparam int POS_PULL_LO = 12;
    localparam int POS_PULL_FORCE = 11;
    localparam int POS_GEN_LO = 4;
    localparam int POS_RX_LO = 2;
    localparam int POS_TX_LO = 0;
    localparam logic [15:0] PAD_CFG_WMASK = 16'h_f83f;

    // Indicator select fields, pin 1 sits eight bits above pin 0
    localparam int POS_SEL_LO = 0;
    localparam int POS_INV = 3;
    localparam int POS_SRC_LO = 4;
    localparam int POS_DIV = 7;
    localparam int IND_STRIDE = 8;
    localparam int POS_FUNC_STRIDE = 4;

    // Output select codes
    typedef enum logic [2:0] {
        SEL_FUNC = 3'h0,
        SEL_CLOCK = 3'h1,
        SEL_INTR = 3'h2,
        SEL_ZERO = 3'h3,
        SEL_RSV4 = 3'h4,
        SEL_RSV5 = 3'h5,
        SEL_CONST0 = 3'h6,
        SEL_CONST1 = 3'h7
    } out_sel_t;

    localparam int NUM_CLK_SRC = 7;
    localparam logic [2:0] CLK_SRC_MAX = 3'h6;

    // APB request and answer
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    // Per-pin indicator configuration
    typedef struct packed {
        out_sel_t sel;
        logic [2:0] clk_src;
        logic div2;
        logic inv;
    } ind_cfg_t;

endpackage

// >>> verilog/indicator_pin_select.sv
// One indicator pin: function, selected clock, interrupt or constant.
// Assumes clock sources arrive as levels sampled on the core clock.
module indicator_pin_select (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire pad_mux_pkg::ind_cfg_t i_cfg,
    input wire logic i_func,
    input wire logic i_intr,
    input wire logic [pad_mux_pkg::NUM_CLK_SRC-1:0] i_clk_src,
    output logic o_pin
);
    import pad_mux_pkg::*;

    logic src_lvl;
    logic src_prev_q;
    logic half_q;
    logic half_d;
    logic clk_lvl;
    logic pin_d;
    logic pin_q;
    wire src_ok = (i_cfg.clk_src <= CLK_SRC_MAX);
    wire clk_mode = (i_cfg.sel == SEL_CLOCK);

    // Source pick; code 7 has no source and reads low
    assign src_lvl = src_ok ? i_clk_src[i_cfg.clk_src] : 1'b0;
    // Halver toggles on each rising edge of the sampled source
    assign half_d = !clk_mode ? 1'b0 :
                    (src_lvl && !src_prev_q) ? !half_q : half_q;
    // Halving first, then inversion
    assign clk_lvl = (i_cfg.div2 ? half_q : src_lvl) ^ i_cfg.inv;

    // Output select; reserved codes drive low
    always_comb begin
        unique case (i_cfg.sel)
            SEL_FUNC: pin_d = i_func;
            SEL_CLOCK: pin_d = clk_lvl;
            SEL_INTR: pin_d = i_intr;
            SEL_CONST1: pin_d = 1'b1;
            default: pin_d = 1'b0;
        endcase
    end

    // Registered so the pin never glitches between selects
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            src_prev_q <= 1'b0;
            half_q <= 1'b0;
            pin_q <= 1'b0;
        end else begin
            src_prev_q <= src_lvl;
            half_q <= half_d;
            pin_q <= pin_d;
        end
    end

    assign o_pin = pin_q;
endmodule

// >>> verilog/pad_force.sv
// Direction and pull forcing for the general pads.
// Assumes normal settings come from the pad owners each cycle.
module pad_force #(
    parameter int NUM_PADS = 8
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_dir_force,
    input wire logic i_dir_val,
    input wire logic i_pull_force,
    input wire logic [1:0] i_pull_val,
    input wire logic [NUM_PADS-1:0] i_norm_oe_n,
    input wire logic [2*NUM_PADS-1:0] i_norm_pull,
    output logic [NUM_PADS-1:0] o_oe_n,
    output logic [2*NUM_PADS-1:0] o_pull
);
    logic [NUM_PADS-1:0] oe_n_d;
    logic [2*NUM_PADS-1:0] pull_d;

    // Per pad: forced value wins only while its force bit is set
    for (genvar p = 0; p < NUM_PADS; p++) begin : g_pad
        assign oe_n_d[p] = i_dir_force ? i_dir_val
                                       : i_norm_oe_n[p];
        assign pull_d[2*p+:2] = i_pull_force ? i_pull_val
                                             : i_norm_pull[2*p+:2];
    end

    // Pads start as inputs with all pull settings at zero
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_oe_n <= '1;
            o_pull <= '0;
        end else begin
            o_oe_n <= oe_n_d;
            o_pull <= pull_d;
        end
    end
endmodule

// >>> verilog/pad_override_and_led_pin_mux.sv
// Pad override, host pad drive and indicator pin mux, with APB registers.
// Assumes an APB master on i_core_clk; status and clock sources are
// levels already synchronous to i_core_clk. MDC, MDIO and reset pads
// are not part of the forced pad vector.

// Function
// - With direction forcing on, every general pad takes its direction from bit 15, 0 output and 1 input.
// - Bit 14 enables direction forcing; when clear, pads follow normal direction and bit 15 is ignored.
// - With bit 11 set, every pad pull setting is forced from the register.
// - Bits 13-12 give the forced pull setting, passed to the pads unencoded.
// - In each host pad drive field (5-4, 3-2, 1-0) the low bit set selects fast slew.
// - Bits 10-8 pick what the second indicator pin drives: function, clock, interrupt, zero, reserved, reserved, zero, one.
// - Bits 2-0 pick what the first indicator pin drives with the same codes.
// - Bits 14-12 pick the clock source of the second indicator pin, codes 0 to 6.
// - Bits 6-4 pick the clock source of the first indicator pin, same codes.
// - Line clocks run free as master and are recovered as slave; the PLL reference is the crystal or half of it.
// - Bit 15 halves the second indicator pin's clock.
// - Bit 11 inverts the second indicator pin's clock.
// - Bit 7 halves the first indicator pin's clock.
// - Bit 3 inverts the first indicator pin's clock.
// - The indicator function of each pin comes from its own four-bit status select.
module pad_override_and_led_pin_mux #(
    parameter int NUM_PADS = 8,
    parameter int NUM_STATUS = 16
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire pad_mux_pkg::apb_req_t i_apb,
    output pad_mux_pkg::apb_rsp_t o_apb,
    input wire logic [NUM_PADS-1:0] i_pad_norm_oe_n,
    input wire logic [2*NUM_PADS-1:0] i_pad_norm_pull,
    output logic [NUM_PADS-1:0] o_pad_oe_n,
    output logic [2*NUM_PADS-1:0] o_pad_pull,
    output logic [1:0] o_gen_drive,
    output logic [1:0] o_rx_drive,
    output logic [1:0] o_tx_drive,
    output logic o_gen_fast_slew,
    output logic o_rx_fast_slew,
    output logic o_tx_fast_slew,
    input wire logic [NUM_STATUS-1:0] i_status,
    input wire logic i_intr,
    input wire logic i_slave_role,
    input wire logic i_crystal_input_clock,
    input wire logic i_pll_ref_half,
    input wire logic i_ld30_free,
    input wire logic i_ld30_rec,
    input wire logic i_conv30_rec,
    input wire logic i_free60,
    input wire logic i_c7p5_free,
    input wire logic i_c7p5_rec,
    input wire logic i_c2p5_free,
    input wire logic i_c2p5_rec,
    output logic [1:0] o_ind_pin
);
    import pad_mux_pkg::*;

    // Parameters the logic cannot serve
    if (NUM_PADS < 1) begin : g_chk_pads
        $error("NUM_PADS must be at least one");
    end
    if (NUM_STATUS < 1 || NUM_STATUS > 16) begin : g_chk_stat
        $error("NUM_STATUS must be 1 to 16");
    end

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    logic [11:0] reg_idx;
    logic word_ok;
    logic hit_pad;
    logic hit_ind;
    logic hit_func;
    logic hit_stat;
    logic hit_any;
    logic setup;
    logic access;
    logic wr_en;

    // Word index from byte address; low two bits must be zero
    assign reg_idx = i_apb.paddr[ADDR_W-1:2];
    assign word_ok = (i_apb.paddr[1:0] == 2'b00);
    assign hit_pad = word_ok && (reg_idx == IDX_PAD_CFG);
    assign hit_ind = word_ok && (reg_idx == IDX_IND_SEL);
    assign hit_func = word_ok && (reg_idx == IDX_IND_FUNC);
    assign hit_stat = word_ok && (reg_idx == IDX_IND_STAT);
    assign hit_any = hit_pad | hit_ind | hit_func | hit_stat;

    // Setup registers read data; access answers one cycle later
    assign setup = i_apb.psel && !i_apb.penable;
    assign access = i_apb.psel && i_apb.penable;
    assign wr_en = access && i_apb.pwrite;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [15:0] pad_cfg_q;
    logic [15:0] pad_cfg_d;
    logic [15:0] ind_sel_q;
    logic [15:0] ind_sel_d;
    logic [15:0] ind_func_q;
    logic [15:0] ind_func_d;

    // Reserved bits 10-6 never store, so they read as zero
    assign pad_cfg_d = (wr_en && hit_pad)
                     ? (i_apb.pwdata[15:0] & PAD_CFG_WMASK) : pad_cfg_q;
    assign ind_sel_d = (wr_en && hit_ind) ? i_apb.pwdata[15:0] : ind_sel_q;
    assign ind_func_d = (wr_en && hit_func)
                      ? i_apb.pwdata[15:0] : ind_func_q;

    // Writes land only at the access edge
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pad_cfg_q <= RST_PAD_CFG;
            ind_sel_q <= RST_IND_SEL;
            ind_func_q <= RST_IND_FUNC;
        end else begin
            pad_cfg_q <= pad_cfg_d;
            ind_sel_q <= ind_sel_d;
            ind_func_q <= ind_func_d;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [15:0] stat_word;
    logic [15:0] rd_word;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pslverr_q;
    logic pslverr_d;

    // Live pin and pad state for software
    assign stat_word = {12'h000, o_ind_pin,
                        pad_cfg_q[POS_PULL_FORCE],
                        pad_cfg_q[POS_DIR_FORCE]};

    assign rd_word = hit_pad ? pad_cfg_q :
                     hit_ind ? ind_sel_q :
                     hit_func ? ind_func_q :
                     hit_stat ? stat_word : 16'h0000;

    // Captured in setup so prdata comes from a flop
    assign prdata_d = setup ? {16'h0000, rd_word} : prdata_q;
    assign pslverr_d = setup ? !hit_any : pslverr_q;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // Answer in the first access cycle; error only in access
    assign o_apb.pready = access;
    assign o_apb.pslverr = access && pslverr_q;
    assign o_apb.prdata = prdata_q;

    // ----------------------------------------------------------------
    // Host pad drive and slew
    // ----------------------------------------------------------------
    logic [1:0] gen_q;
    logic [1:0] rx_q;
    logic [1:0] tx_q;

    // Registered so a field write reaches the pads cleanly
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gen_q <= RST_PAD_CFG[POS_GEN_LO+:2];
            rx_q <= RST_PAD_CFG[POS_RX_LO+:2];
            tx_q <= RST_PAD_CFG[POS_TX_LO+:2];
        end else begin
            gen_q <= pad_cfg_q[POS_GEN_LO+:2];
            rx_q <= pad_cfg_q[POS_RX_LO+:2];
            tx_q <= pad_cfg_q[POS_TX_LO+:2];
        end
    end

    assign o_gen_drive = gen_q;
    assign o_rx_drive = rx_q;
    assign o_tx_drive = tx_q;
    // Low bit of each field is the slew choice
    assign o_gen_fast_slew = gen_q[0];
    assign o_rx_fast_slew = rx_q[0];
    assign o_tx_fast_slew = tx_q[0];

    // ----------------------------------------------------------------
    // Pad direction and pull forcing
    // ----------------------------------------------------------------
    pad_force #(
        .NUM_PADS(NUM_PADS)
    ) u_pad_force (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_dir_force(pad_cfg_q[POS_DIR_FORCE]),
        .i_dir_val(pad_cfg_q[POS_DIR_VAL]),
        .i_pull_force(pad_cfg_q[POS_PULL_FORCE]),
        .i_pull_val(pad_cfg_q[POS_PULL_LO+:2]),
        .i_norm_oe_n(i_pad_norm_oe_n),
        .i_norm_pull(i_pad_norm_pull),
        .o_oe_n(o_pad_oe_n),
        .o_pull(o_pad_pull)
    );

    // ----------------------------------------------------------------
    // Clock source table shared by both pins
    // ----------------------------------------------------------------
    logic [NUM_CLK_SRC-1:0] clk_src;
    logic pll_half_q;

    // Crystal halver, toggled on each crystal rising edge
    logic xtal_prev_q;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            xtal_prev_q <= 1'b0;
            pll_half_q <= 1'b0;
        end else begin
            xtal_prev_q <= i_crystal_input_clock;
            if (i_crystal_input_clock && !xtal_prev_q) begin
                pll_half_q <= !pll_half_q;
            end
        end
    end

    // Role picks free-running or recovered line clocks
    assign clk_src[0] = i_crystal_input_clock;
    assign clk_src[1] = i_slave_role ? i_ld30_rec : i_ld30_free;
    assign clk_src[2] = i_conv30_rec;
    assign clk_src[3] = i_free60;
    assign clk_src[4] = i_slave_role ? i_c7p5_rec : i_c7p5_free;
    assign clk_src[5] = i_pll_ref_half ? pll_half_q
                                       : i_crystal_input_clock;
    assign clk_src[6] = i_slave_role ? i_c2p5_rec : i_c2p5_free;

    // ----------------------------------------------------------------
    // Indicator pins
    // ----------------------------------------------------------------
    // Pin 0 uses the low byte, pin 1 the high byte
    for (genvar k = 0; k < 2; k++) begin : g_ind
        ind_cfg_t cfg;
        logic [3:0] func_sel;
        logic func_lvl;
        localparam int B = k * IND_STRIDE;

        assign cfg.sel = out_sel_t'(ind_sel_q[B+POS_SEL_LO+:3]);
        assign cfg.clk_src = ind_sel_q[B+POS_SRC_LO+:3];
        assign cfg.div2 = ind_sel_q[B+POS_DIV];
        assign cfg.inv = ind_sel_q[B+POS_INV];

        // Status picks beyond the input width read low
        assign func_sel = ind_func_q[k*POS_FUNC_STRIDE+:4];
        assign func_lvl = (int'(func_sel) < NUM_STATUS)
                        ? i_status[func_sel] : 1'b0;

        indicator_pin_select u_pin (
            .i_core_clk(i_core_clk),
            .i_rst_n(i_rst_n),
            .i_cfg(cfg),
            .i_func(func_lvl),
            .i_intr(i_intr),
            .i_clk_src(clk_src),
            .o_pin(o_ind_pin[k])
        );
    end

endmodule

// >>> test/pad_mux_checker.sv
// Concurrent checks on the pad override and indicator mux top ports.
// Assumes writes land at the access edge and outputs lag one edge.
module pad_mux_checker #(
    parameter int NUM_PADS = 8,
    parameter int NUM_STATUS = 16
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire pad_mux_pkg::apb_req_t i_apb,
    input wire pad_mux_pkg::apb_rsp_t o_apb,
    input wire logic [NUM_PADS-1:0] i_pad_norm_oe_n,
    input wire logic [NUM_PADS-1:0] o_pad_oe_n,
    input wire logic [2*NUM_PADS-1:0] o_pad_pull,
    input wire logic [1:0] o_gen_drive,
    input wire logic [1:0] o_rx_drive,
    input wire logic [1:0] o_tx_drive,
    input wire logic o_gen_fast_slew,
    input wire logic o_rx_fast_slew,
    input wire logic o_tx_fast_slew,
    input wire logic [NUM_STATUS-1:0] i_status,
    input wire logic i_intr,
    input wire logic i_crystal_input_clock,
    input wire logic [1:0] o_ind_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    import pad_mux_pkg::*;
    logic [15:0] pad_q, sel_q, fn_q;
    // Decode of the bus request against the register map
    wire acc = i_apb.psel && i_apb.penable;
    wire [13:0] a = i_apb.paddr;
    wire hit_pad = a == {IDX_PAD_CFG, 2'b00};
    wire hit_sel = a == {IDX_IND_SEL, 2'b00};
    wire hit_fn = a == {IDX_IND_FUNC, 2'b00};
    wire mapped = hit_pad || hit_sel || hit_fn || a == {IDX_IND_STAT, 2'b00};
    wire [2:0] s0 = sel_q[2:0];
    wire [2:0] s1 = sel_q[10:8];
    wire st0 = i_status[fn_q[3:0]];
    // Crystal source, no halving: the pin must track it edge for edge
    wire clk0 = s0 == 3'h1 && sel_q[7:4] == 4'h0;
    wire clk1 = s1 == 3'h1 && sel_q[15:12] == 4'h0;
    // Shadow registers rebuilt from bus writes, not read from the design
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pad_q <= RST_PAD_CFG;
            sel_q <= RST_IND_SEL;
            fn_q <= RST_IND_FUNC;
        end else if (acc && i_apb.pwrite) begin
            if (hit_pad) pad_q <= i_apb.pwdata[15:0] & PAD_CFG_WMASK;
            if (hit_sel) sel_q <= i_apb.pwdata[15:0];
            if (hit_fn) fn_q <= i_apb.pwdata[15:0];
        end
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    chk_refuse_unmapped: assert property (acc && !mapped |-> o_apb.pslverr)
        else $error("unmapped access not refused");
    chk_pad_readback: assert property (acc && !i_apb.pwrite && hit_pad
        |-> o_apb.prdata == {16'h0000, pad_q}) else $error("pad readback");
    chk_dir_forced: assert property (
        $past(i_rst_n) && $past(pad_q[14])
        |-> o_pad_oe_n == {NUM_PADS{$past(pad_q[15])}})
        else $error("direction not forced");
    chk_dir_normal: assert property (
        $past(i_rst_n) && !$past(pad_q[14])
        |-> o_pad_oe_n == $past(i_pad_norm_oe_n))
        else $error("direction not normal");
    chk_pull_forced: assert property (
        $past(i_rst_n) && $past(pad_q[11])
        |-> o_pad_pull == {NUM_PADS{$past(pad_q[13:12])}})
        else $error("pull not forced");
    chk_drive_fields: assert property ($past(i_rst_n) |->
        {o_gen_drive, o_rx_drive, o_tx_drive} == $past(pad_q[5:0]))
        else $error("drive field wrong");
    chk_slew_bits: assert property (
        {o_gen_fast_slew, o_rx_fast_slew, o_tx_fast_slew}
        == {o_gen_drive[0], o_rx_drive[0], o_tx_drive[0]})
        else $error("slew bit wrong");
    chk_pin0_low: assert property ($past(i_rst_n) &&
        $past(s0) inside {3'h3, 3'h4, 3'h5, 3'h6} |-> !o_ind_pin[0])
        else $error("first pin not low");
    chk_pin1_high: assert property (
        $past(i_rst_n) && $past(s1) == 3'h7 |-> o_ind_pin[1])
        else $error("second pin not high");
    chk_pin1_intr: assert property (
        $past(i_rst_n) && $past(s1) == 3'h2 |-> o_ind_pin[1] == $past(i_intr))
        else $error("second pin not interrupt");
    chk_pin0_func: assert property (
        $past(i_rst_n) && $past(s0) == 3'h0 |-> o_ind_pin[0] == $past(st0))
        else $error("first pin not status");
    chk_pin0_clock: assert property ($past(i_rst_n) &&
        $past(clk0) |-> o_ind_pin[0] == ($past(i_crystal_input_clock)
        ^ $past(sel_q[3]))) else $error("first pin clock wrong");
    chk_pin1_clock: assert property ($past(i_rst_n) &&
        $past(clk1) |-> o_ind_pin[1] == ($past(i_crystal_input_clock)
        ^ $past(sel_q[11]))) else $error("second pin clock wrong");
    cover property (acc && i_apb.pwrite && hit_sel);
    cover property (clk1 && sel_q[11]);
    cover property (acc && !mapped);
endmodule

bind pad_override_and_led_pin_mux pad_mux_checker #(
    .NUM_PADS(NUM_PADS), .NUM_STATUS(NUM_STATUS)
) u_chk (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_apb(i_apb),
    .o_apb(o_apb), .i_pad_norm_oe_n(i_pad_norm_oe_n),
    .o_pad_oe_n(o_pad_oe_n), .o_pad_pull(o_pad_pull),
    .o_gen_drive(o_gen_drive), .o_rx_drive(o_rx_drive),
    .o_tx_drive(o_tx_drive), .o_gen_fast_slew(o_gen_fast_slew),
    .o_rx_fast_slew(o_rx_fast_slew), .o_tx_fast_slew(o_tx_fast_slew),
    .i_status(i_status), .i_intr(i_intr),
    .i_crystal_input_clock(i_crystal_input_clock), .o_ind_pin(o_ind_pin)
);

// >>> test/board_clock_model.sv
// Board side clock levels feeding the indicator clock mux.
// Assumes sampling on the core clock; half periods are whole cycles.
module board_clock_model (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    output logic [8:0] o_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    // Distinct half periods so a wrong mux leg shows a wrong edge count
    localparam int HALF [9] = '{4, 3, 5, 6, 2, 10, 12, 15, 20};
    int cnt;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) cnt <= 0;
        else cnt <= cnt + 1;
    end
    always_comb begin
        for (int k = 0; k < 9; k++) o_clk[k] = ((cnt / HALF[k]) % 2) == 1;
    end
endmodule

// >>> test/pad_override_and_led_pin_mux_tb.sv
// Self-checking bench for the pad override and indicator pin mux.
// Assumes the board clock model and the bound checker beside the design.
module pad_override_and_led_pin_mux_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pad_mux_pkg::*;
    typedef struct packed {
        logic err;
        logic rd;
        logic [31:0] data;
    } note_t;
    logic i_core_clk, i_rst_n = 1'b0, intr = 1'b0, role = 1'b0, ph = 1'b0;
    apb_req_t i_apb = '0;
    apb_rsp_t o_apb;
    logic [7:0] norm_oe = '1, oe_n;
    logic [15:0] norm_pull = '0, pull, status = '0;
    logic [1:0] gen, rx, tx, pin;
    logic [2:0] slew;
    logic [8:0] src;
    note_t notes[$];
    note_t nt;
    int err_total, n_tests;
    pad_override_and_led_pin_mux dut (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_apb(i_apb),
        .o_apb(o_apb), .i_pad_norm_oe_n(norm_oe), .i_pad_norm_pull(norm_pull),
        .o_pad_oe_n(oe_n), .o_pad_pull(pull), .o_gen_drive(gen),
        .o_rx_drive(rx), .o_tx_drive(tx), .o_gen_fast_slew(slew[2]),
        .o_rx_fast_slew(slew[1]), .o_tx_fast_slew(slew[0]),
        .i_status(status), .i_intr(intr), .i_slave_role(role),
        .i_crystal_input_clock(src[0]), .i_pll_ref_half(ph),
        .i_ld30_free(src[1]), .i_ld30_rec(src[2]), .i_conv30_rec(src[3]),
        .i_free60(src[4]), .i_c7p5_free(src[5]), .i_c7p5_rec(src[6]),
        .i_c2p5_free(src[7]), .i_c2p5_rec(src[8]), .o_ind_pin(pin)
    );
    board_clock_model u_board (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .o_clk(src)
    );
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // One transfer; the request holds until pready is seen at an edge
    task automatic apb(input logic w, input logic [13:0] a,
                       input logic [31:0] d, input note_t n);
        @(posedge i_core_clk);
        notes.push_back(n);
        i_apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge i_core_clk);
        i_apb.penable <= 1'b1;
        // No local limit: only the watchdog ends a wait for pready
        do begin
            @(posedge i_core_clk);
        end while (o_apb.pready !== 1'b1);
        i_apb.psel <= 1'b0;
        i_apb.penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] idx, input logic [15:0] v);
        apb(1'b1, {idx, 2'b00}, {16'h0000, v}, '0);
    endtask
    task automatic rd(input logic [13:0] a, input logic e, input logic [31:0] d);
        apb(1'b0, a, 32'h0000_0000, '{e, 1'b1, d});
    endtask
    // Registered outputs move one edge after the write; look mid-cycle
    task automatic settle;
        @(posedge i_core_clk);
        @(negedge i_core_clk);
    endtask
    function automatic int half_of(input int s, input logic r, input logic h);
        case (s)
            0: return 4;
            1: return r ? 5 : 3;
            2: return 6;
            3: return 2;
            4: return r ? 12 : 10;
            5: return h ? 8 : 4;
            6: return r ? 20 : 15;
            default: return 0;
        endcase
    endfunction
    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    // Bus answers matched in order against the driver's notes
    always @(posedge i_core_clk) begin
        if (i_apb.psel && i_apb.penable && o_apb.pready === 1'b1) begin
            if (notes.size() > 0) begin
                nt = notes.pop_front();
                check(o_apb.pslverr, nt.err);
                if (nt.rd) check(o_apb.prdata, nt.data);
            end
        end
    end
    initial begin
        repeat (60000) @(posedge i_core_clk);
        err_total++;
        finish_test();
    end
    initial begin
        logic [15:0] v;
        logic [7:0] f;
        int n, hv;
        logic prev;
        void'($urandom(32'hc18a));
        repeat (8) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        settle();
        check({gen, rx, tx, slew}, {6'h05, 3'b011});
        rd({IDX_PAD_CFG, 2'b00}, 1'b0, {16'h0000, RST_PAD_CFG});
        rd({IDX_IND_SEL, 2'b00}, 1'b0, 32'h0000_0000);
        rd(14'h1000, 1'b1, 32'h0000_0000);
        rd({IDX_PAD_CFG, 2'b10}, 1'b1, 32'h0000_0000);
        apb(1'b1, 14'h1004, 32'hffff_ffff, '{1'b1, 1'b0, 32'h0000_0000});
        // Pad forcing against random normal settings, all force mixes
        for (int i = 0; i < 8; i++) begin
            @(posedge i_core_clk);
            norm_oe <= 8'($urandom);
            norm_pull <= 16'($urandom);
            v = 16'($urandom);
            v[14] = i[0];
            v[11] = i[1];
            wr(IDX_PAD_CFG, v);
            settle();
            check(oe_n, v[14] ? {8{v[15]}} : norm_oe);
            check(pull, v[11] ? {8{v[13:12]}} : norm_pull);
            check({gen, rx, tx, slew}, {v[5:0], v[4], v[2], v[0]});
            rd({IDX_PAD_CFG, 2'b00}, 1'b0, {16'h0000, v & PAD_CFG_WMASK});
        end
        // Both forces set last; pins show status bit 0, still low
        rd({IDX_IND_STAT, 2'b00}, 1'b0, 32'h0000_0003);
        // Every non-clock output code on each pin
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 8; c++) begin
                if (c == 1) continue;
                @(posedge i_core_clk);
                intr <= 1'($urandom);
                status <= 16'($urandom);
                f = 8'($urandom);
                wr(IDX_IND_FUNC, {8'h00, f});
                wr(IDX_IND_SEL, 16'(c) << (8 * p));
                settle();
                check(pin[p], c == 0 ? status[p ? f[7:4] : f[3:0]] :
                    c == 2 ? intr : c == 7);
            end
        end
        // Clock mode: edge counts per source, role and halving, with random inversion
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 8; s++) begin
                for (int m = 0; m < 4; m++) begin
                    @(posedge i_core_clk);
                    role <= m[1];
                    ph <= 1'($urandom);
                    wr(IDX_IND_SEL, 16'({m[0], 3'(s), 1'($urandom), 3'h1})
                        << (8 * p));
                    repeat (40) @(negedge i_core_clk);
                    hv = half_of(s, role, ph) * (m[0] ? 2 : 1);
                    n = 0;
                    prev = pin[p];
                    repeat (240) begin
                        @(negedge i_core_clk);
                        if (pin[p] !== prev) n++;
                        prev = pin[p];
                    end
                    check(32'(n), hv == 0 ? 0 : 32'(240 / hv));
                end
            end
        end
        finish_test();
    end
endmodule
